// [dv/rx_framer_model.sv]
// downstream framer model with two reference clock sources
`timescale 1ns/1ps
module rx_framer_model
	import rx_cdr_pkg::*;
(
	input  wire logic              clk,  // block clock
	input  wire logic [WORD_W-1:0] data, // word from the block
	input  wire logic              pclk, // primary clock from the block
	input  wire logic              run,  // sources toggle while high
	input  wire logic [7:0]        pa,   // period of source a, cycles
	input  wire logic [7:0]        pb,   // period of source b, cycles
	output logic                   ra,   // reference source a
	output logic                   rb,   // reference source b
	output logic [WORD_W-1:0]      word  // last captured word
);
	logic       pq = 1'b0; // primary clock a cycle ago
	logic [7:0] ca = 8'h0; // half-period counter a
	logic [7:0] cb = 8'h0; // half-period counter b
	initial ra = 1'b0;
	initial rb = 1'b0;
	initial word = '0;
	//////////////////////////////////////////////////////////////////
	// capture one cycle after the rise, when the word has settled
	always @(posedge clk) begin
		pq <= pclk;
		if (pclk && !pq) begin
			word <= data;
		end
	end
	// sources stand still when stopped, so no stray edge is seen
	always @(posedge clk) begin
		if (run) begin
			ca <= (ca >= pa / 2 - 1) ? 8'h0 : ca + 8'h1;
			cb <= (cb >= pb / 2 - 1) ? 8'h0 : cb + 8'h1;
			ra <= (ca >= pa / 2 - 1) ? ~ra : ra;
			rb <= (cb >= pb / 2 - 1) ? ~rb : rb;
		end
	end
endmodule

// [dv/rx_lock_deser_test.sv]
// self-checking bench for the receive lock-detect and deserializer
`timescale 1ns/1ps
module rx_lock_deser_test;
	import rx_cdr_pkg::*;
	logic clk = 1'b0, srst = 1'b1, ser = 1'b0, lb = 1'b0, run = 1'b1;
	logic ltr_n = 1'b1, sq_n = 1'b1, dl_n = 1'b1, ord = 1'b0, adiv = 1'b0;
	logic rsel = 1'b0, below = 1'b0, det = 1'b0, rd = 1'b0, wr = 1'b0;
	logic [3:0]  addr = 4'h0; // register address
	logic [31:0] wd = 32'h0;  // register write data
	logic [31:0] rdat;        // register read data
	logic [31:0] d;           // value read back
	logic [7:0]  pa = 8'h10;  // nominal period: 64 ticks a window
	logic [7:0]  pb = 8'h10;  // transmit word clock period
	logic [3:0]  pat = 4'h3;  // repeating serial word
	logic [3:0]  q, word;     // data bus and framer capture
	logic [1:0]  k = 2'h0;    // serial phase
	logic        pclk, aclk, lol_n, los_n, irq, ra, rb;
	int          fails = 0;
	int          checked = 0;
	//////////////////////////////////////////////////////////////////
	rx_lock_deser rx_lock_deser_i (.clk(clk), .srst(srst), .serial_rx_input(ser),
		.loopback_serial_data(lb), .reference_clock_input(ra),
		.tx_parallel_clock_input(rb), .reference_select(rsel),
		.lock_to_reference_n(ltr_n), .rx_squelch_n(sq_n),
		.diagnostic_loopback_n(dl_n), .rx_bit_order_select(ord),
		.aux_clock_divider_select(adiv), .signal_below_threshold(below),
		.loss_detect_enable(det), .parallel_rx_data(q),
		.primary_recovered_clock_out(pclk), .auxiliary_recovered_clock_out(aclk),
		.rx_loss_of_lock_n(lol_n), .loss_of_signal_alarm_n(los_n),
		.reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdat), .irq(irq));
	rx_framer_model rx_framer_model_i (.clk(clk), .data(q), .pclk(pclk),
		.run(run), .pa(pa), .pb(pb), .ra(ra), .rb(rb), .word(word));
	initial forever #25 clk = ~clk;
	// serial source: bit 0 of the pattern lands on phase 0 after release
	always @(posedge clk) begin
		k <= srst ? 2'h1 : k + 2'h1;
		ser <= pat[srst ? 2'h0 : k];
		lb <= ~pat[srst ? 2'h0 : k];
	end
	//////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic end_of_test();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wd <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdat;
		@(posedge clk);
	endtask
	// spacing of the last two rises of a clock output
	task automatic per(input logic p, output int n);
		logic o, s;
		int t;
		o = 1'b1;
		t = 0;
		n = 0;
		for (int i = 0; i < 40; i++) begin
			@(posedge clk);
			#1 s = p ? pclk : aclk;
			if (s === 1'b1 && o === 1'b0) begin
				n = i - t;
				t = i;
			end
			o = s;
		end
		@(posedge clk);
	endtask
	//////////////////////////////////////////////////////////////////
	task automatic t_order();
		cyc(40);
		chk("word order low", 32'(word), 32'h3);
		ord <= 1'b1;
		cyc(40);
		chk("word order high", 32'(word), 32'hc);
		ord <= 1'b0;
	endtask
	task automatic t_squelch();
		sq_n <= 1'b0;
		cyc(40);
		chk("squelched word", 32'(word), 32'h0);
		dl_n <= 1'b0; // loopback goes low while squelch is still low, so loopback must win
		cyc(40);
		chk("loopback word", 32'(word), 32'hc);
		dl_n <= 1'b1;
		sq_n <= 1'b1;
	endtask
	task automatic t_clocks();
		int n;
		for (int i = 0; i < 2; i++) begin
			adiv <= i[0];
			cyc(20);
			per(1'b0, n);
			chk("aux period", 32'(n), (i == 1) ? 32'd16 : 32'd4);
		end
		per(1'b1, n);
		chk("primary period", 32'(n), 32'd4);
	endtask
	// windows of 16 edges at 16 cycles: 800 cycles covers three of them
	task automatic t_lock();
		cyc(800);
		chk("locked", 32'(lol_n), 32'h1);
		run <= 1'b0;
		cyc(200);
		chk("reference gone", 32'(lol_n), 32'h0);
		run <= 1'b1;
		cyc(800);
		chk("relocked", 32'(lol_n), 32'h1);
		pa <= 8'h14;
		cyc(800);
		chk("off frequency", 32'(lol_n), 32'h0);
		rsel <= 1'b1;
		cyc(800);
		chk("transmit clock ref", 32'(lol_n), 32'h1);
		rsel <= 1'b0;
		ltr_n <= 1'b0;
		cyc(800);
		chk("held on reference", 32'(lol_n), 32'h1);
		ltr_n <= 1'b1;
		pa <= 8'h10;
		cyc(800);
	endtask
	task automatic t_regs();
		rd_reg(REG_STATUS, d);
		chk("status", d, 32'h5);
		chk("irq masked", 32'(irq), 32'h0);
		wr_reg(REG_ENABLE, 32'h4);
		cyc(2);
		chk("irq raised", 32'(irq), 32'h1);
		rd_reg(REG_ENABLE, d);
		chk("enable", d, 32'h4);
		wr_reg(REG_CLEAR, 32'h4);
		cyc(2);
		chk("irq cleared", 32'(irq), 32'h0);
		wr_reg(REG_STATUS, 32'h0);
		rd_reg(REG_STATUS, d);
		chk("status after clear", d, 32'h1);
		rd_reg(REG_LOCK, d);
		chk("lock register", d, 32'h0);
		rd_reg(4'h2, d);
		chk("unmapped", d, 32'h0);
	endtask
	task automatic t_sigloss();
		det <= 1'b1;
		below <= 1'b1;
		cyc(12);
		chk("alarm", 32'(los_n), 32'h0);
		chk("lock loss on alarm", 32'(lol_n), 32'h0);
		ltr_n <= los_n;
		cyc(12);
		chk("lock kept on ref", 32'(lol_n), 32'h1);
		det <= 1'b0;
		cyc(12);
		chk("alarm disabled", 32'(los_n), 32'h1);
	endtask
	//////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		cyc(2);
		t_order();
		t_squelch();
		t_clocks();
		t_lock();
		t_regs();
		t_sigloss();
		end_of_test();
	end
	// about 5400 cycles expected; over twice that means a hang
	initial begin
		#(12000 * 50);
		fails++;
		end_of_test();
	end
endmodule

// [logic/lock_meter.sv]
// frequency comparison of the divided recovered clock against a reference
`timescale 1ns/1ps
module lock_meter
	import rx_cdr_pkg::*;
#(
	parameter int unsigned MEAS    = MEAS_REF_EDGES, // ref edges per window
	parameter int unsigned EXPECT  = EXPECT_TICKS,   // ticks expected per window
	parameter int unsigned TOL_A   = TOL_ASSERT,     // fail above this deviation
	parameter int unsigned TOL_R   = TOL_RELEASE,    // pass below this deviation
	parameter int unsigned TIMEOUT = REF_TIMEOUT     // cycles to declare no ref
) (
	input  wire logic       clk,       // block clock
	input  wire logic       srst,      // synchronous reset, active high
	input  wire logic       div_tick,  // one pulse per divided recovered period
	input  wire logic       ref_level, // selected, synchronised reference level
	input  wire logic       hold,      // recovered clock held on the reference
	output logic            freq_fail, // deviation beyond tolerance
	output logic            ref_missing, // no valid reference edge lately
	output logic [7:0]      deviation  // last measured deviation, saturated
);
	localparam int unsigned CW = 8;
	localparam int unsigned RW = $clog2(MEAS + 1);
	localparam int unsigned TW = $clog2(TIMEOUT + 1);

	// the tick counter must hold twice the expected count
	if (2 * EXPECT > 255 || MEAS < 2 || TOL_R > TOL_A || TIMEOUT < 2) begin : g_chk
		$error("lock_meter parameters out of range");
	end

	typedef struct packed {
		logic          ref_prev; // reference level one cycle ago
		logic [CW-1:0] ticks;    // divided ticks in this window
		logic [RW-1:0] edges;    // reference edges in this window
		logic [TW-1:0] idle;     // cycles since last reference edge
		logic          fail;
		logic          missing;
		logic [7:0]    dev;
	} meter_t;

	meter_t st_r;   // registered state
	meter_t st_nxt; // next state

	logic          ref_edge;  // rising edge of the reference
	logic [CW-1:0] ticks_now; // ticks including this cycle
	logic [CW-1:0] dev_now;   // absolute deviation this cycle

	assign ref_edge  = ref_level & ~st_r.ref_prev;
	assign ticks_now = st_r.ticks + CW'(div_tick);
	assign dev_now   = (ticks_now > CW'(EXPECT)) ? ticks_now - CW'(EXPECT)
	                                             : CW'(EXPECT) - ticks_now;

	////////////////////////////////////////////////////////////////////////////
	// count ticks between reference edges and judge each full window
	always_comb begin
		st_nxt          = st_r;
		st_nxt.ref_prev = ref_level;
		st_nxt.ticks    = (ticks_now == '1) ? st_r.ticks : ticks_now;
		if (ref_edge) begin
			st_nxt.idle = '0;
			if (st_r.edges == RW'(MEAS - 1)) begin
				st_nxt.edges = '0;
				st_nxt.ticks = '0;
				st_nxt.dev   = dev_now;
				// held clock cannot drift, so no frequency error
				if (hold) begin
					st_nxt.fail = 1'b0;
				end else if (dev_now > CW'(TOL_A)) begin
					st_nxt.fail = 1'b1;
				end else if (dev_now < CW'(TOL_R)) begin
					st_nxt.fail = 1'b0;
				end
			end else begin
				st_nxt.edges = st_r.edges + RW'(1);
			end
		end else if (st_r.idle != TW'(TIMEOUT)) begin
			st_nxt.idle = st_r.idle + TW'(1);
		end
		// a missing reference restarts the window from scratch
		st_nxt.missing = (st_nxt.idle == TW'(TIMEOUT));
		if (st_nxt.missing) begin
			st_nxt.edges = '0;
			st_nxt.ticks = '0;
		end
	end

	// register the whole state
	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= '{ref_prev: 1'b0, ticks: '0, edges: '0, idle: '0,
			          fail: 1'b1, missing: 1'b0, dev: 8'h00};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign freq_fail   = st_r.fail;
	assign ref_missing = st_r.missing;
	assign deviation   = st_r.dev;
endmodule

// [logic/pin_sync.sv]
// three-flop synchroniser with agreement filter for a vector of pins
`timescale 1ns/1ps
module pin_sync #(
	parameter int unsigned  W   = 1,   // number of pins
	parameter logic [W-1:0] RST = '0   // filtered level during reset
) (
	input  wire logic         clk,  // block clock
	input  wire logic         srst, // synchronous reset, active high
	input  wire logic [W-1:0] d,    // raw pin levels
	output logic      [W-1:0] q     // filtered levels
);
	typedef struct packed {
		logic [W-1:0] s1; // first stage, read only by s2
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} sync_t;

	sync_t st_r;  // registered state
	sync_t st_nxt; // next state

	////////////////////////////////////////////////////////////////////////////
	// a change counts once stages two and three agree, so a single
	// metastable sample can never reach the data bus
	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int i = 0; i < W; i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.q[i] = st_r.s3[i];
			end
		end
	end

	// register the whole state
	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= '{s1: RST, s2: RST, s3: RST, q: RST};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.q;
endmodule

// [logic/rx_cdr_pkg.sv]
// constants shared by the receive lock-detect and deserializer block
package rx_cdr_pkg;
	localparam int unsigned WORD_W       = 4;          // deserializer word width
	localparam int unsigned CLK_HZ       = 20_000_000; // recovered bit clock rate
	localparam int unsigned AUX_DIV_LO   = 4;          // aux clock ratio, select low
	localparam int unsigned AUX_DIV_HI   = 16;         // aux clock ratio, select high
	// lock measurement: window of reference edges and expected divided ticks
	localparam int unsigned MEAS_REF_EDGES = 16;       // reference edges per window
	localparam int unsigned EXPECT_TICKS   = 64;       // divided ticks per window
	localparam int unsigned TOL_ASSERT     = 2;        // deviation above this fails
	localparam int unsigned TOL_RELEASE    = 1;        // deviation below this passes
	localparam int unsigned REF_TIMEOUT    = 64;       // cycles without a ref edge
	// synchronised pin vector layout
	localparam int unsigned PIN_REF      = 0;  // dedicated reference clock
	localparam int unsigned PIN_TXC      = 1;  // transmit parallel clock
	localparam int unsigned PIN_RSEL     = 2;  // reference select
	localparam int unsigned PIN_LOCKREF  = 3;  // lock_to_reference_n
	localparam int unsigned PIN_SQ       = 4;  // rx_squelch_n
	localparam int unsigned PIN_DIAG     = 5;  // diagnostic_loopback_n
	localparam int unsigned PIN_ORDER    = 6;  // rx_bit_order_select
	localparam int unsigned PIN_AUXDIV   = 7;  // aux_clock_divider_select
	localparam int unsigned PIN_BELOW    = 8;  // amplitude below threshold
	localparam int unsigned PIN_DET_EN   = 9;  // signal-loss detection enable
	localparam int unsigned PIN_W        = 10; // number of synchronised pins
	localparam logic [9:0]  PIN_RST      = 10'h038; // active-low pins idle high
	// register port
	localparam int unsigned ADDR_W       = 4;
	localparam logic [3:0]  REG_STATUS   = 4'h0; // sticky events, read only
	localparam logic [3:0]  REG_CLEAR    = 4'h4; // write one to clear, write only
	localparam logic [3:0]  REG_ENABLE   = 4'h8; // interrupt enables
	localparam logic [3:0]  REG_LOCK     = 4'hc; // live lock state, read only
	// event bit positions
	localparam int unsigned EV_LOL       = 0;  // loss of lock went active
	localparam int unsigned EV_SIGLOSS   = 1;  // signal-loss alarm went active
	localparam int unsigned EV_NOREF     = 2;  // reference clock vanished
	localparam int unsigned EV_W         = 3;
	localparam logic [2:0]  ENABLE_RST   = 3'h0;
	localparam logic        LOL_RST      = 1'b1; // unlocked until first window
endpackage

// [logic/rx_lock_deser.sv]
// receive lock detection, 1:4 deserializer, clocks, squelch and registers
//
// Summary of operation
// - group four received bits into one word
// - word changes on primary clock rising edge
// - order low: first bit on bit 0
// - order high: first bit on bit 3
// - aux clock is quarter or sixteenth rate
// - squelch low forces data bus to zero
// - diagnostic loopback overrides squelch
// - compare divided clock with selected reference
// - assert lock loss beyond tolerance, hysteresis
// - unlocked clock may drift about 1000 ppm; here both clock outputs run from clk and never drift
// - missing reference asserts lock loss
// - signal loss asserts lock loss unless held
// - lock-to-reference holds clocks on reference; here it only clears frequency fail and masks signal loss
// - alarm active low, high when detection disabled
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module rx_lock_deser
	import rx_cdr_pkg::*;
(
	input  wire logic              clk,                      // recovered bit clock
	input  wire logic              srst,                     // sync reset, high
	input  wire logic              serial_rx_input,          // retimed recovered bit
	input  wire logic              loopback_serial_data,     // serializer output bit
	input  wire logic              reference_clock_input,    // dedicated reference
	input  wire logic              tx_parallel_clock_input,  // transmit word clock
	input  wire logic              reference_select,         // high: transmit clock
	input  wire logic              lock_to_reference_n,      // low: hold on ref
	input  wire logic              rx_squelch_n,             // low: zero the data
	input  wire logic              diagnostic_loopback_n,    // low: loopback path
	input  wire logic              rx_bit_order_select,      // high: first bit on 3
	input  wire logic              aux_clock_divider_select, // high: divide by 16
	input  wire logic              signal_below_threshold,   // amplitude too small
	input  wire logic              loss_detect_enable,       // signal-loss enable
	output logic [WORD_W-1:0]      parallel_rx_data,         // deserialized word
	output logic                   primary_recovered_clock_out,   // bit clock / 4
	output logic                   auxiliary_recovered_clock_out, // / 4 or / 16
	output logic                   rx_loss_of_lock_n,        // low: not locked
	output logic                   loss_of_signal_alarm_n,   // low: signal lost
	input  wire logic [ADDR_W-1:0] reg_addr,                 // register address
	input  wire logic [31:0]       reg_wdata,                // write data
	input  wire logic              reg_wr,                   // write strobe
	input  wire logic              reg_rd,                   // read strobe
	output logic [31:0]            reg_rdata,                // read data, next cycle
	output logic                   irq                       // level interrupt
);
	typedef struct packed {
		logic [1:0]        phase;   // bit position within the word
		logic [WORD_W-1:0] asm_w;   // bits gathered, first at bit 0
		logic [WORD_W-1:0] pending; // completed word awaiting the clock edge
		logic [WORD_W-1:0] data;    // word on the bus
		logic              pclk;    // primary clock output
		logic [3:0]        aux_cnt; // free divider for the aux clock
		logic              aux;     // aux clock output
		logic              lol;     // loss of lock, active high internally
		logic              sigloss_n;  // alarm output
		logic              sigloss_prev; // for edge events
		logic              noref_prev;   // for edge events
		logic [EV_W-1:0]   status;  // sticky events
		logic [EV_W-1:0]   enable;  // interrupt enables
		logic [31:0]       rdata;   // read answer
		logic              irq;     // interrupt output
	} state_t;

	state_t st_r;   // registered state
	state_t st_nxt; // next state

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisation and selection

	logic [PIN_W-1:0] pin_q;      // filtered control and clock pins
	logic             diag_act;   // diagnostic loopback selected
	logic             sq_force;   // squelch takes effect
	logic             lockref_act; // recovered clock held on the reference
	logic             sigloss_act; // signal-loss condition
	logic             ref_level;  // chosen reference level
	logic             ser;        // serial bit feeding the deserializer
	logic             freq_fail;  // from the lock meter
	logic             ref_missing; // from the lock meter
	logic [7:0]       deviation;  // from the lock meter
	logic             div_tick;   // one per primary clock period
	logic [EV_W-1:0]  ev;         // events this cycle
	logic [EV_W-1:0]  clr;        // clear mask written this cycle

	pin_sync #(
		.W   (PIN_W),
		.RST (PIN_RST)
	) u_sync (
		.clk  (clk),
		.srst (srst),
		.d    ({loss_detect_enable, signal_below_threshold, aux_clock_divider_select,
		        rx_bit_order_select, diagnostic_loopback_n, rx_squelch_n,
		        lock_to_reference_n, reference_select, tx_parallel_clock_input,
		        reference_clock_input}),
		.q    (pin_q)
	);

	assign diag_act    = ~pin_q[PIN_DIAG];
	assign sq_force    = ~pin_q[PIN_SQ] & ~diag_act;
	assign lockref_act = ~pin_q[PIN_LOCKREF];
	assign sigloss_act = pin_q[PIN_DET_EN] & pin_q[PIN_BELOW];
	// reference chosen by the select pin
	assign ref_level   = pin_q[PIN_RSEL] ? pin_q[PIN_TXC] : pin_q[PIN_REF];
	// loopback bits come from our own serializer, same clock, no sync
	assign ser         = diag_act ? loopback_serial_data : serial_rx_input;
	assign div_tick    = (st_r.phase == 2'd3);

	// the recovered clock here always runs from clk, so the drift that an
	// analog loop shows while reacquiring never appears at these outputs
	lock_meter u_meter (
		.clk         (clk),
		.srst        (srst),
		.div_tick    (div_tick),
		.ref_level   (ref_level),
		.hold        (lockref_act),
		.freq_fail   (freq_fail),
		.ref_missing (ref_missing),
		.deviation   (deviation)
	);

	// map gathered bits to the bus according to the order select
	function automatic logic [WORD_W-1:0] order_word(
		input logic [WORD_W-1:0] w,
		input logic              first_high
	);
		logic [WORD_W-1:0] r;
		r = w;
		if (first_high) begin
			for (int i = 0; i < WORD_W; i++) begin
				r[WORD_W-1-i] = w[i];
			end
		end
		return r;
	endfunction

	assign ev[EV_LOL]     = st_nxt.lol & ~st_r.lol;
	assign ev[EV_SIGLOSS] = sigloss_act & ~st_r.sigloss_prev;
	assign ev[EV_NOREF]   = ref_missing & ~st_r.noref_prev;
	assign clr            = (reg_wr && reg_addr == REG_CLEAR) ? reg_wdata[EV_W-1:0] : '0;

	////////////////////////////////////////////////////////////////////////////
	// next-state logic for data path, clocks, lock and registers
	always_comb begin
		st_nxt = st_r;
		// deserializer: one bit per clk, four per word
		st_nxt.phase            = st_r.phase + 2'd1;
		st_nxt.asm_w[st_r.phase] = ser;
		if (st_r.phase == 2'd3) begin
			st_nxt.pending = order_word({ser, st_r.asm_w[2:0]}, pin_q[PIN_ORDER]);
		end
		// bus loads in the same cycle that the primary clock rises
		if (st_r.phase == 2'd1) begin
			st_nxt.data = sq_force ? '0 : st_r.pending;
		end
		st_nxt.pclk = st_nxt.phase[1];
		// aux clock; switching the select mid-period may shorten one phase
		st_nxt.aux_cnt = st_r.aux_cnt + 4'd1;
		st_nxt.aux     = pin_q[PIN_AUXDIV] ? st_nxt.aux_cnt[3] : st_nxt.aux_cnt[1];
		// lock loss combines frequency, reference and signal conditions
		st_nxt.lol = freq_fail | ref_missing
		           | (sigloss_act & ~lockref_act);
		st_nxt.sigloss_n    = ~sigloss_act;
		st_nxt.sigloss_prev = sigloss_act;
		st_nxt.noref_prev   = ref_missing;
		// sticky status: a new event beats a clear in the same cycle
		st_nxt.status = (st_r.status & ~clr) | ev;
		if (reg_wr && reg_addr == REG_ENABLE) begin
			st_nxt.enable = reg_wdata[EV_W-1:0];
		end
		st_nxt.irq = |(st_nxt.status & st_nxt.enable);
		// read data live for one cycle only; unmapped reads give zero
		st_nxt.rdata = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				REG_STATUS: st_nxt.rdata = 32'(st_r.status);
				REG_ENABLE: st_nxt.rdata = 32'(st_r.enable);
				REG_LOCK:   st_nxt.rdata = {16'h0000, deviation, 3'b000,
				                            lockref_act, sigloss_act, ref_missing,
				                            freq_fail, st_r.lol};
				default:    st_nxt.rdata = 32'h0000_0000;
			endcase
		end
	end

	// register the whole state
	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= '{phase: 2'd0, asm_w: '0, pending: '0, data: '0, pclk: 1'b0,
			          aux_cnt: 4'h0, aux: 1'b0, lol: LOL_RST, sigloss_n: 1'b1,
			          sigloss_prev: 1'b0, noref_prev: 1'b0, status: '0,
			          enable: ENABLE_RST, rdata: 32'h0000_0000, irq: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign parallel_rx_data              = st_r.data;
	assign primary_recovered_clock_out   = st_r.pclk;
	assign auxiliary_recovered_clock_out = st_r.aux;
	assign rx_loss_of_lock_n             = ~st_r.lol;
	assign loss_of_signal_alarm_n        = st_r.sigloss_n;
	assign reg_rdata                     = st_r.rdata;
	assign irq                           = st_r.irq;

	////////////////////////////////////////////////////////////////////////////
	// assertions and covers

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_first_bit_low: assert property (
		(st_r.phase == 2'd0) ##6 (!$past(pin_q[PIN_ORDER], 3) && !$past(sq_force, 1))
		|-> parallel_rx_data[0] == $past(ser, 6))
		else $error("first bit not on bit 0");

	a_first_bit_high: assert property (
		(st_r.phase == 2'd0) ##6 ($past(pin_q[PIN_ORDER], 3) && !$past(sq_force, 1))
		|-> parallel_rx_data[3] == $past(ser, 6))
		else $error("first bit not on bit 3");

	a_data_on_edge: assert property (
		$changed(parallel_rx_data) |-> $rose(primary_recovered_clock_out))
		else $error("data changed off the primary clock edge");

	a_squelch_zero: assert property (
		(st_r.phase == 2'd1 && sq_force) |=> parallel_rx_data == '0)
		else $error("squelched word not zero");

	a_diag_pass: assert property (
		(st_r.phase == 2'd1 && diag_act && st_r.pending != '0)
		|=> parallel_rx_data != '0)
		else $error("loopback word squelched");

	a_aux_quarter: assert property (
		($rose(auxiliary_recovered_clock_out) && !pin_q[PIN_AUXDIV] && !$past(pin_q[PIN_AUXDIV]))
		##1 (!pin_q[PIN_AUXDIV])[*4] |-> $rose(auxiliary_recovered_clock_out))
		else $error("aux clock not at quarter rate");

	a_aux_sixteenth: assert property (
		($rose(auxiliary_recovered_clock_out) && pin_q[PIN_AUXDIV] && $past(pin_q[PIN_AUXDIV]))
		##1 pin_q[PIN_AUXDIV][*8] ##1 pin_q[PIN_AUXDIV][*8]
		|-> $rose(auxiliary_recovered_clock_out))
		else $error("aux clock not at sixteenth rate");

	a_noref_unlock: assert property (
		ref_missing |=> !rx_loss_of_lock_n)
		else $error("missing reference did not assert lock loss");

	a_sigloss_unlock: assert property (
		(sigloss_act && !lockref_act) |=> !rx_loss_of_lock_n)
		else $error("signal loss did not assert lock loss");

	a_alarm_disabled: assert property (
		!pin_q[PIN_DET_EN] |=> loss_of_signal_alarm_n)
		else $error("alarm active with detection disabled");

	c_lock_gained: cover property ($rose(rx_loss_of_lock_n));
	c_squelched:   cover property (st_r.phase == 2'd1 && sq_force);
	c_loopback:    cover property (st_r.phase == 2'd1 && diag_act);
	c_irq:         cover property ($rose(irq));
endmodule
